// [logic/debounce_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface debounce_if;
  import gpio_bank_pkg::*;
  dbvec_t raw;
  dbvec_t enable;
  dbcnt_t portLen;
  dbcnt_t rstLen;
  dbvec_t filt;
  modport filter (input raw, input enable, input portLen, input rstLen,
                  output filt);
  modport user (output raw, output enable, output portLen, output rstLen,
                input filt);
endinterface : debounce_if
`default_nettype wire

// [logic/gpio_bank_pkg.sv]
`default_nettype none
package gpio_bank_pkg;
  typedef logic [17:0] pinvec_t;
  typedef logic [18:0] dbvec_t;
  typedef logic [12:0] dbcnt_t;
  typedef logic [14:0] anavec_t;
endpackage : gpio_bank_pkg
`default_nettype wire

// [logic/gpio_bank_regs.svh]
`ifndef GPIO_BANK_REGS_SVH
`define GPIO_BANK_REGS_SVH

`define OFS_P0_DATA 8'h80
`define OFS_P1_DATA 8'h88
`define OFS_P0_DIR 8'h89
`define OFS_P2_DATA 8'h90
`define OFS_P1_DIR 8'h91
`define OFS_P2_DIR 8'h99
`define OFS_P0_OD 8'hb1
`define OFS_P1_OD 8'hb9
`define OFS_P2_OD 8'hc1
`define OFS_P0_PU 8'hd1
`define OFS_P1_PU 8'hd9
`define OFS_DEB_SEL 8'hda
`define OFS_ANA_LO 8'hdc
`define OFS_ANA_HI 8'hdd
`define OFS_P2_PU 8'he1
`define OFS_P0_DB 8'he2
`define OFS_P1_DB 8'he3
`define OFS_P2_DB 8'he4

`define PIN_CNT 18
`define OD_RST 18'h00004
`define PIN_RST 18'h00000
`define DEB_SEL_RST 4'h0
`define ANA_LO_RST 8'h00
`define ANA_HI_RST 7'h00
`define DEB_PORT_LSB 0
`define DEB_RST_LSB 2
`define FILT_RST 19'h40000
`define RST_PIN_IDX 18

`define CLK_PERIOD_NS 8
`define PORT_DEB_BASE_US 1
`define RST_DEB_BASE_US 8
`define PORT_DEB_BASE_CYC ((`PORT_DEB_BASE_US * 1000) / `CLK_PERIOD_NS)
`define RST_DEB_BASE_CYC ((`RST_DEB_BASE_US * 1000) / `CLK_PERIOD_NS)

`endif

// [logic/gpio_port_bank.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bank_regs.svh"
module gpio_port_bank
  import gpio_bank_pkg::*;
#(
  parameter int RstDebBaseCyc = `RST_DEB_BASE_CYC
) (
  input wire logic mclk, // System clock, 125 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [7:0] sfrAddr, // Special function register address.
  input wire logic sfrWr, // Write strobe, one cycle.
  input wire logic sfrRd, // Read strobe, one cycle.
  input wire logic [7:0] sfrWdata, // Write data.
  output logic [7:0] sfrRdata, // Read data, valid the cycle after sfrRd.
  input wire logic [17:0] pinIn, // Pad input levels.
  output logic [17:0] pinOut, // Pad output levels.
  output logic [17:0] pinOeN, // Pad output enables, low drives.
  output logic [17:0] pinPullUp, // Pad pull-up enables.
  output logic [14:0] analogEn, // Analog channel enables.
  output logic [17:0] digIn, // Filtered digital inputs to the core.
  input wire logic extRstInN, // External reset pad, active low.
  output logic extRstOutN // Debounced external reset, active low.
);
  pinvec_t data_q, data_d;
  pinvec_t dir_q, dir_d;
  pinvec_t pu_q, pu_d;
  pinvec_t od_q, od_d;
  pinvec_t db_q, db_d;
  logic [3:0] debSel_q, debSel_d;
  logic [7:0] anaLo_q, anaLo_d;
  logic [6:0] anaHi_q, anaHi_d;
  logic [7:0] rdData_q, rdData_d;
  pinvec_t pinOut_q, pinOut_d;
  pinvec_t pinOeN_q, pinOeN_d;
  pinvec_t pinPullUp_q;
  anavec_t analogEn_q;
  pinvec_t digIn_q, digIn_d;
  logic extRst_q;
  pinvec_t anaDis;
  pinvec_t pinState;
  logic [7:0] rdMux;

  debounce_if dbi ();

  pin_debounce uDeb (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .dbi(dbi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Maps the two analog select registers onto pin positions; P02 has no
  // channel, so the low register skips pin 2.
  function automatic pinvec_t anaToPins(input logic [7:0] lo,
                                        input logic [6:0] hi);
    pinvec_t m;
    m = '0;
    m[1:0] = lo[1:0];
    m[8:3] = lo[7:2];
    m[12:11] = hi[1:0];
    m[17:13] = hi[6:2];
    return m;
  endfunction : anaToPins

  // Shifted base length; the widest product, 8000 cycles, fits 13 bits.
  function automatic dbcnt_t debLen(input int base, input logic [1:0] sel);
    return dbcnt_t'(base << sel);
  endfunction : debLen

  ////////////////////////////////////////////////////////////////////////////
  assign anaDis = anaToPins(anaLo_q, anaHi_q);
  assign dbi.raw = {extRstInN, pinIn};
  assign dbi.enable = {1'b1, db_q};
  assign dbi.portLen = debLen(`PORT_DEB_BASE_CYC,
                              debSel_q[`DEB_PORT_LSB +: 2]);
  assign dbi.rstLen = debLen(RstDebBaseCyc,
                             debSel_q[`DEB_RST_LSB +: 2]);

  // Analog pins read zero so a mid-rail level never toggles the core.
  assign pinState = dbi.filt[17:0] & ~anaDis;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_comb begin
    data_d = data_q;
    dir_d = dir_q;
    pu_d = pu_q;
    od_d = od_q;
    db_d = db_q;
    debSel_d = debSel_q;
    anaLo_d = anaLo_q;
    anaHi_d = anaHi_q;
    if (sfrWr) begin
      unique case (sfrAddr)
        `OFS_P0_DATA: data_d[7:0] = sfrWdata;
        `OFS_P1_DATA: data_d[15:8] = sfrWdata;
        `OFS_P2_DATA: data_d[17:16] = sfrWdata[1:0];
        `OFS_P0_DIR: dir_d[7:0] = sfrWdata;
        `OFS_P1_DIR: dir_d[15:8] = sfrWdata;
        `OFS_P2_DIR: dir_d[17:16] = sfrWdata[1:0];
        `OFS_P0_PU: pu_d[7:0] = sfrWdata;
        `OFS_P1_PU: pu_d[15:8] = sfrWdata;
        `OFS_P2_PU: pu_d[17:16] = sfrWdata[1:0];
        `OFS_P0_OD: od_d[7:0] = sfrWdata;
        `OFS_P1_OD: od_d[15:8] = sfrWdata;
        `OFS_P2_OD: od_d[17:16] = sfrWdata[1:0];
        `OFS_P0_DB: db_d[7:0] = sfrWdata;
        `OFS_P1_DB: db_d[15:8] = sfrWdata;
        `OFS_P2_DB: db_d[17:16] = sfrWdata[1:0];
        `OFS_DEB_SEL: debSel_d = sfrWdata[3:0];
        `OFS_ANA_LO: anaLo_d = sfrWdata;
        `OFS_ANA_HI: anaHi_d = sfrWdata[6:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_q <= `PIN_RST;
      dir_q <= `PIN_RST;
      pu_q <= `PIN_RST;
      od_q <= `OD_RST;
      db_q <= `PIN_RST;
      debSel_q <= `DEB_SEL_RST;
      anaLo_q <= `ANA_LO_RST;
      anaHi_q <= `ANA_HI_RST;
    end else begin
      data_q <= data_d;
      dir_q <= dir_d;
      pu_q <= pu_d;
      od_q <= od_d;
      db_q <= db_d;
      debSel_q <= debSel_d;
      anaLo_q <= anaLo_d;
      anaHi_q <= anaHi_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads. Data reads mix the latch for outputs with the filtered
  // pad for inputs; unused bits and unmapped addresses read zero.
  always_comb begin
    pinvec_t dv;
    dv = (dir_q & data_q) | (~dir_q & pinState);
    unique case (sfrAddr)
      `OFS_P0_DATA: rdMux = dv[7:0];
      `OFS_P1_DATA: rdMux = dv[15:8];
      `OFS_P2_DATA: rdMux = {6'h00, dv[17:16]};
      `OFS_P0_DIR: rdMux = dir_q[7:0];
      `OFS_P1_DIR: rdMux = dir_q[15:8];
      `OFS_P2_DIR: rdMux = {6'h00, dir_q[17:16]};
      `OFS_P0_PU: rdMux = pu_q[7:0];
      `OFS_P1_PU: rdMux = pu_q[15:8];
      `OFS_P2_PU: rdMux = {6'h00, pu_q[17:16]};
      `OFS_P0_OD: rdMux = od_q[7:0];
      `OFS_P1_OD: rdMux = od_q[15:8];
      `OFS_P2_OD: rdMux = {6'h00, od_q[17:16]};
      `OFS_P0_DB: rdMux = db_q[7:0];
      `OFS_P1_DB: rdMux = db_q[15:8];
      `OFS_P2_DB: rdMux = {6'h00, db_q[17:16]};
      `OFS_DEB_SEL: rdMux = {4'h0, debSel_q};
      `OFS_ANA_LO: rdMux = anaLo_q;
      `OFS_ANA_HI: rdMux = {1'b0, anaHi_q};
      default: rdMux = 8'h00;
    endcase
    rdData_d = sfrRd ? rdMux : rdData_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive. An open-drain pin only pulls low and floats for a one.
  always_comb begin
    pinOut_d = data_q & ~od_q;
    pinOeN_d = ~(dir_q & (~od_q | ~data_q));
    digIn_d = pinState;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData_q <= 8'h00;
      pinOut_q <= `PIN_RST;
      pinOeN_q <= ~`PIN_RST;
      pinPullUp_q <= `PIN_RST;
      analogEn_q <= 15'h0000;
      digIn_q <= `PIN_RST;
      extRst_q <= 1'b1;
    end else begin
      rdData_q <= rdData_d;
      pinOut_q <= pinOut_d;
      pinOeN_q <= pinOeN_d;
      pinPullUp_q <= pu_q;
      analogEn_q <= {anaHi_q, anaLo_q};
      digIn_q <= digIn_d;
      extRst_q <= dbi.filt[`RST_PIN_IDX];
    end
  end

  assign sfrRdata = rdData_q;
  assign pinOut = pinOut_q;
  assign pinOeN = pinOeN_q;
  assign pinPullUp = pinPullUp_q;
  assign analogEn = analogEn_q;
  assign digIn = digIn_q;
  assign extRstOutN = extRst_q;
endmodule : gpio_port_bank
`default_nettype wire

// [logic/pin_debounce.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bank_regs.svh"
module pin_debounce
  import gpio_bank_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  debounce_if.filter dbi // Raw levels in, filtered levels out.
);
  dbcnt_t cnt_q [19];
  dbcnt_t cnt_d [19];
  dbvec_t filt_q;
  dbvec_t filt_d;
  localparam dbvec_t FiltRst = `FILT_RST;

  assign dbi.filt = filt_q;

  ////////////////////////////////////////////////////////////////////////////
  // The last channel is the reset input and always filters with its own
  // length; the counter restarts whenever the raw level returns, so a glitch
  // shorter than the length never gets through an enabled channel; a disabled channel passes the raw level.
  genvar i;
  generate
    for (i = 0; i < 19; i++) begin : gPin
      dbcnt_t len;
      assign len = (i == `RST_PIN_IDX) ? dbi.rstLen : dbi.portLen;
      always_comb begin
        cnt_d[i] = cnt_q[i];
        filt_d[i] = filt_q[i];
        if (!dbi.enable[i]) begin
          filt_d[i] = dbi.raw[i];
          cnt_d[i] = '0;
        end else if (dbi.raw[i] == filt_q[i]) begin
          cnt_d[i] = '0;
        end else if (cnt_q[i] + 13'h0001 >= len) begin
          filt_d[i] = dbi.raw[i];
          cnt_d[i] = '0;
        end else begin
          cnt_d[i] = cnt_q[i] + 13'h0001;
        end
      end
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          cnt_q[i] <= '0;
          filt_q[i] <= FiltRst[i];
        end else begin
          cnt_q[i] <= cnt_d[i];
          filt_q[i] <= filt_d[i];
        end
      end
    end
  endgenerate
endmodule : pin_debounce
`default_nettype wire

// [testbench/board_pads.sv]
`timescale 1ns/1ps
`default_nettype none
module board_pads (
  input wire logic mclk, // Clock for the floating pattern.
  input wire logic [17:0] pinOut, // Device levels.
  input wire logic [17:0] pinOeN, // Device enables, low drives.
  input wire logic [17:0] pinPullUp, // Device pull-ups.
  input wire logic [17:0] extVal, // Board levels.
  input wire logic [17:0] extEn, // Board drives where high.
  output logic [17:0] pinIn // Resolved pad levels.
);
  // A line nobody drives or pulls wanders, so nothing may rely on it.
  logic [17:0] float_q = 18'h00000;
  always @(posedge mclk) float_q <= ~float_q;
  assign pinIn = (~pinOeN & pinOut)
               | (pinOeN & extEn & extVal)
               | (pinOeN & ~extEn & (pinPullUp | float_q));
endmodule : board_pads
`default_nettype wire

// [testbench/gpio_port_bank_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bank_regs.svh"
module gpio_port_bank_monitor
  import gpio_bank_pkg::*;
#(
  parameter int RstDebBaseCyc = 4
) (
  input wire logic mclk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic [7:0] sfrAddr, // Address.
  input wire logic sfrWr, // Write strobe.
  input wire logic sfrRd, // Read strobe.
  input wire logic [7:0] sfrWdata, // Write data.
  input wire logic [7:0] sfrRdata, // Read data.
  input wire logic [17:0] pinIn, // Pad levels.
  input wire logic [17:0] pinOut, // Pad outputs.
  input wire logic [17:0] pinOeN, // Pad enables.
  input wire logic [17:0] pinPullUp, // Pull-ups.
  input wire logic [14:0] analogEn, // Analog enables.
  input wire logic [17:0] digIn, // Core inputs.
  input wire logic extRstInN, // Reset pad.
  input wire logic extRstOutN // Filtered reset.
);
  logic [17:0] anaPin;
  logic lastIn_q;
  logic [15:0] runCnt_q;
  logic [15:0] runCnt_d;
  assign anaPin = {analogEn[14:8], 2'b00, analogEn[7:2], 1'b0, analogEn[1:0]};
  always_comb begin
    runCnt_d = (extRstInN != lastIn_q) ? 16'h0000
                                       : runCnt_q + {15'h0000, ~&runCnt_q};
  end
  always_ff @(posedge mclk) begin
    runCnt_q <= sys_rst ? 16'h0000 : runCnt_d;
    lastIn_q <= sys_rst ? 1'b1 : extRstInN;
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_RESET_STATE: assert property ($past(sys_rst) |->
    &pinOeN && pinPullUp == 18'h0 && analogEn == 15'h0 && extRstOutN)
    else $error("outputs not at reset state");
  AST_DIR_INPUT: assert property (sfrWr && sfrAddr == `OFS_P0_DIR &&
    sfrWdata == 8'h00 ##1 !sfrWr |=> pinOeN[7:0] == 8'hff)
    else $error("input pin still driven");
  AST_PULLUP: assert property (sfrWr && sfrAddr == `OFS_P0_PU ##1
    !sfrWr |=> pinPullUp[7:0] == $past(sfrWdata, 2))
    else $error("pull-up output wrong");
  AST_P2_UNUSED: assert property (sfrRd && sfrAddr == `OFS_P2_DATA
    |=> sfrRdata[7:2] == 6'h00) else $error("port 2 upper bits set");
  AST_ANA_HI: assert property (sfrWr && sfrAddr == `OFS_ANA_HI ##1
    !sfrWr |=> analogEn[14:8] == $past(sfrWdata[6:0], 2))
    else $error("analog enables wrong");
  AST_ANA_DIG: assert property ((anaPin & $past(anaPin) & digIn) == 0)
    else $error("analog pin seen as digital");
  AST_DIG_SOURCE: assert property (((digIn & ~$past(digIn))
    & ~$past(pinIn, 2)) == 18'h0) else $error("core input rose alone");
  AST_RST_MIN: assert property ($changed(extRstOutN) |->
    extRstOutN == lastIn_q && runCnt_q >= RstDebBaseCyc - 1)
    else $error("reset filter too quick");
  AST_RST_MAX: assert property (runCnt_q > 8 * RstDebBaseCyc + 2
    |-> extRstOutN == lastIn_q) else $error("reset filter too slow");
  cover property ($fell(extRstOutN));
  cover property (sfrRd && sfrAddr == `OFS_P2_DATA);
  cover property (|analogEn);
endmodule : gpio_port_bank_monitor
bind gpio_port_bank gpio_port_bank_monitor #(.RstDebBaseCyc(RstDebBaseCyc))
  gpio_port_bank_monitor_inst (.mclk, .sys_rst, .sfrAddr, .sfrWr, .sfrRd,
  .sfrWdata, .sfrRdata, .pinIn, .pinOut, .pinOeN, .pinPullUp, .analogEn,
  .digIn, .extRstInN, .extRstOutN);
`default_nettype wire

// [testbench/test_gpio_port_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module test_gpio_port_bank
  import gpio_bank_pkg::*;
;
  localparam int RstBase = 4;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata;
  logic extRstInN = 1'b1;
  logic extRstOutN;
  pinvec_t pinIn, pinOut, pinOeN, pinPullUp, digIn;
  pinvec_t extVal = '0;
  pinvec_t extEn = '0;
  anavec_t analogEn;
  int errors = 0;
  int tests_run = 0;
  int n;
  logic [7:0] d;
  always #4 mclk = ~mclk;
  gpio_port_bank #(.RstDebBaseCyc(RstBase)) gpio_port_bank_inst (.mclk,
    .sys_rst, .sfrAddr, .sfrWr, .sfrRd, .sfrWdata, .sfrRdata, .pinIn, .pinOut,
    .pinOeN, .pinPullUp, .analogEn, .digIn, .extRstInN, .extRstOutN);
  board_pads board_pads_inst (.mclk, .pinOut, .pinOeN, .pinPullUp, .extVal,
    .extEn, .pinIn);
  //////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [17:0] seen,
                     input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfrAddr <= a;
    sfrWdata <= v;
    sfrWr <= 1'b1;
    @(posedge mclk);
    sfrWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    sfrAddr <= a;
    sfrRd <= 1'b1;
    @(posedge mclk);
    sfrRd <= 1'b0;
    @(negedge mclk);
    v = sfrRdata;
  endtask : rd
  task automatic look;
    repeat (5) @(negedge mclk);
  endtask : look
  // Index 18 stands for the external reset pad.
  task automatic settle(input int idx, input logic v, output int cnt);
    @(posedge mclk);
    if (idx == 18) extRstInN <= v;
    else extVal[idx] <= v;
    cnt = 0;
    do begin
      @(negedge mclk);
      cnt++;
    end while (((idx == 18) ? extRstOutN : digIn[idx]) !== v && cnt < 9000);
  endtask : settle
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] ofs [15] = '{8'h89, 8'h91, 8'h99, 8'hb1, 8'hb9, 8'hc1,
      8'hd1, 8'hd9, 8'hda, 8'hdc, 8'hdd, 8'he1, 8'he2, 8'he3, 8'he4};
    chk("oe at reset", pinOeN, 18'h3ffff);
    chk("pull-up at reset", pinPullUp, 18'h0);
    foreach (ofs[i]) begin
      rd(ofs[i], d);
      chk("reset value", d, (ofs[i] == 8'hb1) ? 8'h04 : 8'h00);
    end
  endtask : t_reset
  task automatic t_unused;
    logic [7:0] a [5] = '{8'h99, 8'hda, 8'hdd, 8'h00, 8'hd1};
    logic [7:0] e [5] = '{8'h03, 8'h0f, 8'h7f, 8'h00, 8'h5a};
    foreach (a[i]) begin
      wr(a[i], (i == 4) ? 8'h5a : 8'hff);
      rd(a[i], d);
      chk("masked bits", d, e[i]);
      if (i == 4) chk("pull-up out", pinPullUp[7:0], 8'h5a);
      wr(a[i], 8'h00);
    end
  endtask : t_unused
  task automatic t_output;
    wr(8'h89, 8'hff);
    wr(8'h80, 8'ha5);
    look;
    chk("od pin out", pinOut[7:0], 8'ha1);
    chk("od pin oe", pinOeN[7:0], 8'h04);
    wr(8'hb1, 8'h00);
    look;
    chk("pp pin out", pinOut[7:0], 8'ha5);
    chk("pp pin oe", pinOeN[7:0], 8'h00);
    rd(8'h80, d);
    chk("latch read", d, 8'ha5);
    wr(8'h89, 8'h00);
    look;
    chk("input oe", pinOeN[7:0], 8'hff);
  endtask : t_output
  task automatic t_input;
    @(posedge mclk);
    extEn <= 18'h0ff00;
    extVal <= 18'h03c00;
    wr(8'he1, 8'h03);
    look;
    chk("pad to core", digIn[17:8], 10'h33c);
    rd(8'h88, d);
    chk("input read", d, 8'h3c);
    rd(8'h90, d);
    chk("pulled read", d, 8'h03);
  endtask : t_input
  task automatic t_analog;
    @(posedge mclk);
    extVal <= 18'h0ff00;
    wr(8'hdc, 8'h80);
    wr(8'hdd, 8'h7f);
    look;
    chk("analog enables", analogEn, 15'h7f80);
    chk("analog pins low", digIn[17:8], 10'h006);
    rd(8'h88, d);
    chk("analog read", d, 8'h06);
    wr(8'hdd, 8'h00);
    wr(8'hdc, 8'h00);
    look;
    chk("digital back", digIn[17:8], 10'h3ff);
  endtask : t_analog
  task automatic t_debounce;
    @(posedge mclk);
    extVal <= 18'h0;
    wr(8'he3, 8'h01);
    look;
    @(posedge mclk);
    extVal[8] <= 1'b1;
    n = 0;
    for (int c = 0; c < 200; c++) begin
      @(posedge mclk);
      if (c == 60) extVal[8] <= 1'b0;
      @(negedge mclk);
      if (digIn[8] !== 1'b0) n++;
    end
    chk("short pulse", 18'(n), 18'h0);
    for (int s = 0; s < 4; s++) begin
      wr(8'hda, 8'(s));
      settle(8, 1'b1, n);
      chk("filter rise", 18'(n), 18'((125 << s) + 2));
      settle(8, 1'b0, n);
      chk("filter fall", 18'(n), 18'((125 << s) + 2));
    end
    wr(8'he3, 8'h00);
    settle(8, 1'b1, n);
    chk("unfiltered", 18'(n), 18'h3);
  endtask : t_debounce
  task automatic t_extrst;
    for (int s = 0; s < 4; s++) begin
      wr(8'hda, 8'(s << 2));
      settle(18, 1'b0, n);
      chk("reset assert", 18'(n), 18'((RstBase << s) + 2));
      settle(18, 1'b1, n);
      chk("reset release", 18'(n), 18'((RstBase << s) + 2));
    end
  endtask : t_extrst
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_unused;
    t_output;
    t_input;
    t_analog;
    t_debounce;
    t_extrst;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    stop_test;
  end
endmodule : test_gpio_port_bank
`default_nettype wire
